// file: rtl/ppw_port_event.v
`timescale 1ns/1ns
`default_nettype none
`include "ppw_map.vh"
module ppw_port_event #(
  parameter integer FILT_CYC = `PPW_FILT_TICK_CYC
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_a_in,
  input wire [7:0] port_b_in,
  input wire [7:0] port_c_in,
  input wire [7:0] port_a_dir,
  input wire [7:0] port_b_dir,
  input wire [7:0] port_c_dir,
  output reg [2:0] pullup_en,
  output reg [7:0] drive_strong,
  output reg port_b_pin_six_heavy,
  output reg port_b_pin_seven_heavy,
  output reg event_irq,
  output reg wake_req,
  output reg wake_reset_req
);

  localparam [1:0] LV_IDLE = 2'h0;
  localparam [1:0] LV_ARM = 2'h1;
  localparam [1:0] LV_LEFT = 2'h2;
  localparam [1:0] LV_RET = 2'h3;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function is_mapped;
    input [13:0] idx;
    begin
      is_mapped = (idx == `PPW_IDX_PULLUP) || (idx == `PPW_IDX_DRIVE) ||
        (idx == `PPW_IDX_EVT_EN) || (idx == `PPW_IDX_TRIG) ||
        (idx == `PPW_IDX_WAKE) || (idx == `PPW_IDX_MODESEL) ||
        (idx == `PPW_IDX_FLAG_A) || (idx == `PPW_IDX_FLAG_B) ||
        (idx == `PPW_IDX_FLAG_C);
    end
  endfunction

  function [1:0] trig_mode_of;
    input [7:0] trig;
    input integer n;
    begin
      trig_mode_of = trig[n*2 +: 2];
    end
  endfunction

  reg [7:0] pullup_reg;
  reg [7:0] drive_reg;
  reg [7:0] evt_en_reg;
  reg [7:0] trig_reg;
  reg [7:0] wake_reg;
  reg bit_mode_reg;
  reg [15:0] flag_ab_reg;
  reg [7:0] flag_c_reg;
  reg [15:0] flag_ab_next;
  reg [7:0] flag_c_next;

  reg aw_held_reg;
  reg w_held_reg;
  reg [13:0] aw_idx_reg;
  reg [7:0] w_data_reg;
  reg w_lane_reg;
  wire wr_go;
  wire [13:0] ar_idx;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign ar_idx = s_axi_araddr[15:2];

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPW_RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 14'h0000;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else begin
      // ready stays low while a response waits, so no address is taken then
      s_axi_awready <= !aw_held_reg && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_reg && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_idx_reg) ? `PPW_RESP_OKAY : `PPW_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pullup_reg <= `PPW_CFG_RESET;
      drive_reg <= `PPW_CFG_RESET;
      evt_en_reg <= `PPW_CFG_RESET;
      trig_reg <= `PPW_CFG_RESET;
      wake_reg <= `PPW_CFG_RESET;
      bit_mode_reg <= 1'b0;
    end else if (wr_go && w_lane_reg) begin
      case (aw_idx_reg)
        `PPW_IDX_PULLUP: pullup_reg <= w_data_reg;
        `PPW_IDX_DRIVE: drive_reg <= w_data_reg;
        `PPW_IDX_EVT_EN: evt_en_reg <= w_data_reg;
        `PPW_IDX_TRIG: trig_reg <= w_data_reg;
        `PPW_IDX_WAKE: wake_reg <= w_data_reg;
        `PPW_IDX_MODESEL: bit_mode_reg <= w_data_reg[`PPW_BIT_MODE_POS];
        default: bit_mode_reg <= bit_mode_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PPW_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(ar_idx) ? `PPW_RESP_OKAY : `PPW_RESP_SLVERR;
        case (ar_idx)
          `PPW_IDX_PULLUP: s_axi_rdata <= {24'h000000, pullup_reg};
          `PPW_IDX_DRIVE: s_axi_rdata <= {24'h000000, drive_reg};
          `PPW_IDX_EVT_EN: s_axi_rdata <= {24'h000000, evt_en_reg};
          `PPW_IDX_TRIG: s_axi_rdata <= {24'h000000, trig_reg};
          `PPW_IDX_WAKE: s_axi_rdata <= {24'h000000, wake_reg};
          `PPW_IDX_MODESEL: s_axi_rdata <= {24'h000000, bit_mode_reg, 7'h00};
          `PPW_IDX_FLAG_A: s_axi_rdata <= {24'h000000, flag_ab_reg[7:0]};
          `PPW_IDX_FLAG_B: s_axi_rdata <= {24'h000000, flag_ab_reg[15:8]};
          `PPW_IDX_FLAG_C: s_axi_rdata <= {24'h000000, flag_c_reg};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // debounce filter on port_a and port_b
  // ----------------------------------------------------------------
  reg [15:0] tick_cnt_reg;
  reg tick_reg;
  reg [15:0] filt_prev_reg;
  reg [15:0] filt_stab_reg;
  wire [15:0] raw_ab;
  wire [15:0] dir_ab;
  wire [15:0] filt_mask;
  wire [15:0] eff_ab;
  wire [7:0] eff_c;

  assign raw_ab = {port_b_in, port_a_in};
  assign dir_ab = {port_b_dir, port_a_dir};
  assign filt_mask = {{4{evt_en_reg[7]}}, {4{evt_en_reg[6]}},
    {4{evt_en_reg[5]}}, {4{evt_en_reg[4]}}};
  // output pins read high so they can neither edge nor break all-high
  assign eff_ab = ((filt_mask & filt_stab_reg) | (~filt_mask & raw_ab)) | dir_ab;
  assign eff_c = port_c_in | port_c_dir;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
      filt_prev_reg <= 16'hFFFF;
      filt_stab_reg <= 16'hFFFF;
    end else begin
      tick_reg <= 1'b0;
      if (tick_cnt_reg >= FILT_CYC[15:0] - 16'h0001) begin
        tick_cnt_reg <= 16'h0000;
        tick_reg <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
      if (tick_reg) begin
        filt_prev_reg <= raw_ab;
        filt_stab_reg <= (filt_stab_reg & ~(raw_ab ~^ filt_prev_reg)) |
          (raw_ab & (raw_ab ~^ filt_prev_reg));
      end
    end
  end

  // ----------------------------------------------------------------
  // trigger evaluation
  // ----------------------------------------------------------------
  reg [15:0] last_ab_reg;
  reg [7:0] last_c_reg;
  reg [7:0] lvl_st_reg;
  reg [7:0] lvl_st_next;
  reg [3:0] lvl_trig;
  reg [15:0] set_ab;
  reg [7:0] set_c;
  reg [5:0] hit_nib;
  reg [3:0] nib;
  reg [3:0] pin_hit;
  reg [1:0] st;
  reg [1:0] md;
  integer n;
  wire [15:0] rise_ab;
  wire [15:0] fall_ab;
  wire [15:0] chg_ab;
  wire [7:0] rise_c;
  wire [7:0] fall_c;

  assign rise_ab = eff_ab & ~last_ab_reg;
  assign fall_ab = ~eff_ab & last_ab_reg;
  assign chg_ab = eff_ab ^ last_ab_reg;
  assign rise_c = eff_c & ~last_c_reg;
  assign fall_c = ~eff_c & last_c_reg;

  always @* begin
    lvl_st_next = lvl_st_reg;
    lvl_trig = 4'h0;
    set_ab = 16'h0000;
    hit_nib = 6'h00;
    nib = 4'h0;
    pin_hit = 4'h0;
    st = LV_IDLE;
    md = `PPW_TRIG_RISE;
    for (n = 0; n < 4; n = n + 1) begin
      nib = eff_ab[n*4 +: 4];
      st = lvl_st_reg[n*2 +: 2];
      md = trig_mode_of(trig_reg, n);
      case (st)
        LV_IDLE: if (&nib) lvl_st_next[n*2 +: 2] = LV_ARM;
        LV_ARM: if (!(&nib)) lvl_st_next[n*2 +: 2] = LV_LEFT;
        LV_LEFT: begin
          if (&nib) begin
            if (md == `PPW_TRIG_LVL2) begin
              lvl_trig[n] = 1'b1;
              lvl_st_next[n*2 +: 2] = LV_ARM;
            end else begin
              lvl_st_next[n*2 +: 2] = LV_RET;
            end
          end
        end
        LV_RET: begin
          if (!(&nib)) begin
            lvl_trig[n] = (md == `PPW_TRIG_LVL1);
            lvl_st_next[n*2 +: 2] = LV_LEFT;
          end
        end
        default: lvl_st_next[n*2 +: 2] = LV_IDLE;
      endcase
      case (md)
        `PPW_TRIG_RISE: pin_hit = rise_ab[n*4 +: 4];
        `PPW_TRIG_FALL: pin_hit = fall_ab[n*4 +: 4];
        default: pin_hit = lvl_trig[n] ? chg_ab[n*4 +: 4] : 4'h0;
      endcase
      if (bit_mode_reg) begin
        if (n == 0) begin
          if (md == `PPW_TRIG_RISE || md == `PPW_TRIG_FALL)
            set_ab[3:0] = pin_hit & evt_en_reg[3:0];
          else
            set_ab[3:0] = chg_ab[3:0] & evt_en_reg[3:0];
        end
      end else if (evt_en_reg[n]) begin
        set_ab[n*4 +: 4] = pin_hit;
      end
      hit_nib[n] = |set_ab[n*4 +: 4];
    end
    set_c = {{4{wake_reg[7]}} & rise_c[7:4],
      {2{wake_reg[6]}} & fall_c[3:2], {2{wake_reg[6]}} & rise_c[1:0]};
    hit_nib[4] = |set_c[3:0];
    hit_nib[5] = |set_c[7:4];
  end

  // ----------------------------------------------------------------
  // event flags, clear by writing zero
  // ----------------------------------------------------------------
  always @* begin
    flag_ab_next = flag_ab_reg;
    flag_c_next = flag_c_reg;
    if (wr_go && w_lane_reg) begin
      case (aw_idx_reg)
        `PPW_IDX_FLAG_A: flag_ab_next[7:0] = flag_ab_reg[7:0] & w_data_reg;
        `PPW_IDX_FLAG_B: flag_ab_next[15:8] = flag_ab_reg[15:8] & w_data_reg;
        `PPW_IDX_FLAG_C: flag_c_next = flag_c_reg & w_data_reg;
        default: flag_c_next = flag_c_reg;
      endcase
    end
    // a new event wins over a same-cycle clear
    flag_ab_next = flag_ab_next | set_ab;
    flag_c_next = flag_c_next | set_c;
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_ab_reg <= 16'hFFFF;
      last_c_reg <= 8'hFF;
      lvl_st_reg <= 8'h00;
      flag_ab_reg <= 16'h0000;
      flag_c_reg <= 8'h00;
      event_irq <= 1'b0;
      wake_req <= 1'b0;
      wake_reset_req <= 1'b0;
    end else begin
      last_ab_reg <= eff_ab;
      last_c_reg <= eff_c;
      lvl_st_reg <= lvl_st_next;
      flag_ab_reg <= flag_ab_next;
      flag_c_reg <= flag_c_next;
      event_irq <= (|flag_ab_next) || (|flag_c_next);
      wake_req <= |hit_nib;
      wake_reset_req <= |(hit_nib & wake_reg[5:0]);
    end
  end

  // ----------------------------------------------------------------
  // pad controls
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pullup_en <= 3'h0;
      drive_strong <= 8'h00;
      port_b_pin_six_heavy <= 1'b0;
      port_b_pin_seven_heavy <= 1'b0;
    end else begin
      pullup_en <= pullup_reg[2:0];
      drive_strong <= drive_reg;
      port_b_pin_six_heavy <= drive_reg[3];
      port_b_pin_seven_heavy <= drive_reg[3];
    end
  end

endmodule
`default_nettype wire

// file: rtl/ppw_map.vh
// Overview of operation
// - pull-up select bits 2,1,0 enable pull-ups for port_b low, port_a high, port_a low
// - each drive-strength bit picks weak or strong drive for one nibble, port_d high down
// - port_b pins six and seven use the heavier drive pair from the same bit
// - event enable bits 7..4 insert debounce on port_b high/low, port_a high/low
// - in nibble mode event enable bits 3..0 permit events from the four nibbles
// - in bit mode event enable bits 3..0 enable port_a pins 3..0 individually
// - trigger bits 7-6 select port_b high mode: rise, fall, level one, level two
// - trigger bits 5-4 select port_b low mode with the same encoding
// - trigger bits 3-0 hold the two port_a nibble modes, same encoding
// - level one: armed all-high, left, returned, next departure triggers
// - level two: armed all-high, every return to all-high after leaving triggers
// - wake-reset bit 7 enables port_c high nibble events, rising edges only
// - wake-reset bit 6 enables port_c low: pins 1:0 rising, pins 3:2 falling
// - wake-reset bits 5..1 choose resume only or resume with reset per nibble
// - wake-reset bit 0 chooses resume only or with reset for port_a low
// - mode select bit 7 chooses nibble control or per-bit control of port_a 3..0
// - a pin raises no event while set as output, but switching it to output reads as a rise
`ifndef PPW_MAP_VH
`define PPW_MAP_VH
`define PPW_IDX_PULLUP 14'h102B
`define PPW_IDX_DRIVE 14'h102C
`define PPW_IDX_EVT_EN 14'h102D
`define PPW_IDX_TRIG 14'h102E
`define PPW_IDX_WAKE 14'h102F
`define PPW_IDX_MODESEL 14'h1034
`define PPW_IDX_FLAG_A 14'h1022
`define PPW_IDX_FLAG_B 14'h1026
`define PPW_IDX_FLAG_C 14'h102A
`define PPW_CFG_RESET 8'h00
`define PPW_BIT_MODE_POS 7
`define PPW_TRIG_RISE 2'h0
`define PPW_TRIG_FALL 2'h1
`define PPW_TRIG_LVL1 2'h2
`define PPW_TRIG_LVL2 2'h3
`define PPW_FILT_TICK_NS 1000
`define PPW_CLK_PERIOD_NS 100
`define PPW_FILT_TICK_CYC (`PPW_FILT_TICK_NS / `PPW_CLK_PERIOD_NS)
`define PPW_RESP_OKAY 2'h0
`define PPW_RESP_SLVERR 2'h2
`endif

// file: sim/ppw_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module ppw_pin_model (
  input wire logic sys_clk,
  input wire logic [23:0] pin_tgt,
  output logic [7:0] port_a_in,
  output logic [7:0] port_b_in,
  output logic [7:0] port_c_in
);
  // ----------------------------------------
  // switch contacts settle one edge late
  // ----------------------------------------
  initial {port_c_in, port_b_in, port_a_in} = 24'h0;
  always @(posedge sys_clk) {port_c_in, port_b_in, port_a_in} <= pin_tgt;
endmodule
`default_nettype wire

// file: sim/ppw_port_event_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ppw_port_event_assertions #(
  parameter integer FILT_CYC = 10
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] port_a_dir,
  input wire logic [7:0] port_b_dir,
  input wire logic [7:0] port_c_dir,
  input wire logic [7:0] drive_strong,
  input wire logic port_b_pin_six_heavy,
  input wire logic port_b_pin_seven_heavy,
  input wire logic event_irq,
  input wire logic wake_req,
  input wire logic wake_reset_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  six_heavy_a: assert property (port_b_pin_six_heavy == drive_strong[3])
    else $error("pin six drive differs from nibble select");
  seven_heavy_a: assert property (port_b_pin_seven_heavy == drive_strong[3])
    else $error("pin seven drive differs from nibble select");
  reset_with_wake_a: assert property (wake_reset_req |-> wake_req)
    else $error("reset request without wake");
  flag_holds_irq_a: assert property (wake_req |-> event_irq)
    else $error("new event without irq level");
  output_quiet_a: assert property ((&{port_a_dir, port_b_dir, port_c_dir})[*3] |-> !wake_req)
    else $error("event from output pins");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while response pending");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  rdata_top_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  read_after_ar_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
    else $error("read data without address handshake");
endmodule
bind ppw_port_event ppw_port_event_assertions #(.FILT_CYC(FILT_CYC)) chk_u (.*);
`default_nettype wire

// file: sim/ppw_port_event_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppw_map.vh"
module ppw_port_event_test;
  logic sys_clk = 1'h0, rst_b = 1'h0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] port_a_dir = 8'h0, port_b_dir = 8'h0, port_c_dir = 8'h0;
  logic [23:0] pin_tgt = 24'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port_a_in, port_b_in, port_c_in, drive_strong;
  wire [2:0] pullup_en;
  wire port_b_pin_six_heavy, port_b_pin_seven_heavy, event_irq, wake_req, wake_reset_req;
  int miscompares = 0, comparisons = 0, cyc = 0;
  logic [29:0] rows [0:5] = '{{`PPW_IDX_PULLUP, 8'h05, 8'h05}, {`PPW_IDX_DRIVE, 8'h5A, 8'h5A},
    {`PPW_IDX_TRIG, 8'h1F, 8'h1F}, {`PPW_IDX_MODESEL, 8'hFF, 8'h80},
    {`PPW_IDX_WAKE, 8'hA5, 8'hA5}, {`PPW_IDX_EVT_EN, 8'hF0, 8'hF0}};

  always #50 sys_clk = ~sys_clk;
  ppw_pin_model pins_u (.*);
  ppw_port_event #(.FILT_CYC(2)) dut_u (.*);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [13:0] i, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
    logic a, w;
    @(posedge sys_clk);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    a = 1'h1;
    w = 1'h1;
    while (a || w) begin
      @(posedge sys_clk);
      a = a && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= a;
      s_axi_wvalid <= w;
    end
    while (!s_axi_bvalid) @(posedge sys_clk);
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'h0;
  endtask

  task set(input logic [13:0] i, input logic [7:0] d);
    wr(i, d, 4'hF, `PPW_RESP_OKAY);
  endtask

  task rd(input logic [13:0] i, input logic [7:0] e, input logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    while (!s_axi_rvalid) @(posedge sys_clk);
    chk(s_axi_rdata, {24'h0, e});
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'h0;
  endtask

  task pulse(input logic [23:0] t, input logic e, input logic r);
    logic seen, rr;
    seen = 1'h0;
    rr = 1'h0;
    @(posedge sys_clk);
    pin_tgt <= t;
    repeat (12) begin
      @(posedge sys_clk);
      rr = seen ? rr : wake_reset_req;
      seen = seen | (wake_req === 1'h1);
    end
    chk(seen, e);
    if (e) chk(rr, r);
  endtask

  task do_reset;
    rst_b <= 1'h0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge sys_clk);
  endtask

  task close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      close_out;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset;
    chk({pullup_en, drive_strong, port_b_pin_six_heavy, port_b_pin_seven_heavy}, 32'h0);
    chk({event_irq, wake_req, wake_reset_req}, 32'h0);
    for (int k = 0; k < 6; k++) rd(rows[k][29:16], 8'h00, `PPW_RESP_OKAY);
    $display("reset values done");
    for (int k = 0; k < 6; k++) begin
      set(rows[k][29:16], rows[k][15:8]);
      rd(rows[k][29:16], rows[k][7:0], `PPW_RESP_OKAY);
    end
    chk(pullup_en, 3'h5);
    chk(drive_strong, 8'h5A);
    chk({port_b_pin_six_heavy, port_b_pin_seven_heavy}, 2'h3);
    wr(14'h1030, 8'hFF, 4'hF, `PPW_RESP_SLVERR);
    rd(14'h1030, 8'h00, `PPW_RESP_SLVERR);
    wr(`PPW_IDX_PULLUP, 8'h00, 4'hE, `PPW_RESP_OKAY);
    rd(`PPW_IDX_PULLUP, 8'h05, `PPW_RESP_OKAY);
    $display("registers done");
    set(`PPW_IDX_WAKE, 8'h01);
    set(`PPW_IDX_MODESEL, 8'h00);
    set(`PPW_IDX_TRIG, 8'h00);
    set(`PPW_IDX_EVT_EN, 8'h01);
    pulse(24'h000001, 1'h1, 1'h1);
    rd(`PPW_IDX_FLAG_A, 8'h01, `PPW_RESP_OKAY);
    set(`PPW_IDX_FLAG_A, 8'h00);
    rd(`PPW_IDX_FLAG_A, 8'h00, `PPW_RESP_OKAY);
    chk(event_irq, 1'h0);
    pulse(24'h000000, 1'h0, 1'h0);
    set(`PPW_IDX_TRIG, 8'h01);
    pulse(24'h000001, 1'h0, 1'h0);
    pulse(24'h000000, 1'h1, 1'h1);
    set(`PPW_IDX_EVT_EN, 8'h00);
    pulse(24'h000001, 1'h0, 1'h0);
    pulse(24'h000000, 1'h0, 1'h0);
    set(`PPW_IDX_EVT_EN, 8'h01);
    @(posedge sys_clk);
    port_a_dir <= 8'hFF;
    port_b_dir <= 8'hFF;
    port_c_dir <= 8'hFF;
    pulse(24'h000001, 1'h0, 1'h0);
    pulse(24'h000000, 1'h0, 1'h0);
    // releasing the outputs looks like a fall, so events go off first
    set(`PPW_IDX_EVT_EN, 8'h00);
    port_a_dir <= 8'h00;
    port_b_dir <= 8'h00;
    port_c_dir <= 8'h00;
    pulse(24'h040000, 1'h0, 1'h0);
    set(`PPW_IDX_WAKE, 8'h80);
    pulse(24'h140000, 1'h1, 1'h0);
    set(`PPW_IDX_WAKE, 8'h50);
    pulse(24'h100000, 1'h1, 1'h1);
    pulse(24'h110000, 1'h1, 1'h1);
    pulse(24'h11F000, 1'h0, 1'h0);
    set(`PPW_IDX_TRIG, 8'hC0);
    set(`PPW_IDX_EVT_EN, 8'h08);
    pulse(24'h11A000, 1'h0, 1'h0);
    pulse(24'h11F000, 1'h1, 1'h0);
    pulse(24'h11B000, 1'h0, 1'h0);
    pulse(24'h11F000, 1'h1, 1'h0);
    set(`PPW_IDX_TRIG, 8'h80);
    pulse(24'h11E000, 1'h0, 1'h0);
    pulse(24'h11F000, 1'h0, 1'h0);
    pulse(24'h11B000, 1'h1, 1'h0);
    set(`PPW_IDX_TRIG, 8'h00);
    set(`PPW_IDX_MODESEL, 8'h80);
    set(`PPW_IDX_EVT_EN, 8'h04);
    pulse(24'h11B008, 1'h0, 1'h0);
    set(`PPW_IDX_EVT_EN, 8'h08);
    pulse(24'h11B000, 1'h0, 1'h0);
    pulse(24'h11B008, 1'h1, 1'h0);
    set(`PPW_IDX_MODESEL, 8'h00);
    set(`PPW_IDX_EVT_EN, 8'h11);
    @(posedge sys_clk);
    pin_tgt <= 24'h11B00A;
    pulse(24'h11B008, 1'h0, 1'h0);
    pulse(24'h11B00A, 1'h1, 1'h0);
    $display("events done");
    do_reset;
    chk({pullup_en, drive_strong, port_b_pin_six_heavy, port_b_pin_seven_heavy}, 32'h0);
    chk({event_irq, wake_req, wake_reset_req}, 32'h0);
    rd(`PPW_IDX_TRIG, 8'h00, `PPW_RESP_OKAY);
    rd(`PPW_IDX_FLAG_A, 8'h00, `PPW_RESP_OKAY);
    $display("second reset done");
    close_out;
  end
endmodule
`default_nettype wire
